// ---- design/ccr_consts.vh ----
// register offsets, field positions and reset values of the charger config bank
// assumes byte-wide registers mapped one per aligned APB word
`ifndef CCR_CONSTS_VH
`define CCR_CONSTS_VH

// printed offsets are register indices, byte address is four times the index
`define CCR_IDX_FLAGS_B 8'h06
`define CCR_IDX_ENABLE_A 8'h07
`define CCR_IDX_ENABLE_B 8'h08
`define CCR_IDX_SUSPEND 8'h09
`define CCR_IDX_LIMIT 8'h0A
`define CCR_IDX_FAST 8'h0B
`define CCR_IDX_CHGEN 8'h0C
`define CCR_IDX_TIMER 8'h0D
`define CCR_IDX_REGV 8'h0E
`define CCR_IDX_PRECHG 8'h10
// own choice: flags of the first interrupt register, index 0x05, clear on read
`define CCR_IDX_FLAGS_A 8'h05

// reset values
`define CCR_RST_ENABLE 8'h00
`define CCR_RST_SUSPEND 8'h30
`define CCR_RST_LIMIT 8'h00
`define CCR_RST_FAST 8'h00
`define CCR_RST_CHGEN 8'h10
`define CCR_RST_TIMER 8'h00
`define CCR_RST_REGV 8'h00
`define CCR_RST_PRECHG 8'h00

// field positions
`define CCR_BIT_SOFT_SUSP 5
`define CCR_BIT_SUSP_SEL 4
`define CCR_BIT_LIMIT_MODE 7
`define CCR_BIT_REG_RANGE 3
`define CCR_BIT_THR_SEL 7
`define CCR_BIT_HOT 1
`define CCR_BIT_CONTACT 6

// current limit codes in mA
`define CCR_MA_0 12'h000
`define CCR_MA_100 12'h064
`define CCR_MA_500 12'h1F4
`define CCR_MA_600 12'h258
`define CCR_MA_700 12'h2BC
`define CCR_MA_900 12'h384
`define CCR_MA_1000 12'h3E8
`define CCR_MA_1500 12'h5DC
`define CCR_MA_2000 12'h7D0

// battery temperature zone code of the hot range
`define CCR_ZONE_HOT 3'h3

`endif

// ---- design/ccr_charger_config_irq_regs.v ----
// configuration and interrupt register bank of a usb charger detector, apb slave
// assumes event and status inputs are synchronous pulses/levels, pins are async
//
// Notes on behaviour
// - contact detect timeout sets its flag
// - entering hot zone sets hot flag
// - first enable register gates first flags
// - second enable register gates second flags
// - suspend select chooses pin or software
// - software suspend low forces zero limit
// - auto mode limit from detected type
// - manual mode uses switch and limit fields
// - manual limit field code table
// - done threshold code table
// - maintain timer code table
// - precharge timer code table
// - low regulation field voltage table
// - low precharge threshold table
// - high precharge threshold table
// - bus supply rising edge reloads defaults of the config registers, enables keep their values
`timescale 1ns/1ps
`include "ccr_consts.vh"

module ccr_charger_config_irq_regs #(
    parameter ADDR_WIDTH = 12
) (
    input wire clk_sys,
    input wire nrst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_WIDTH-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [7:0] eventsA,
    input wire [7:0] eventsB,
    input wire contactTimeout,
    input wire [2:0] tempZone,
    input wire [3:0] detected_source_type,
    input wire suspend_pin,
    input wire bus_supply_input,
    output reg irqRequest,
    output reg forceSuspend,
    output reg [11:0] inputLimitMa,
    output reg [6:0] doneThresholdMa,
    output reg [5:0] maintainTimerMin,
    output reg [7:0] prechargeTimerMin,
    output reg [12:0] regulationMv,
    output reg [6:0] prechargeCurrentMa,
    output reg [11:0] prechargeThresholdMv,
    output reg [2:0] fastChargeCode,
    output reg regulationHighSel,
    output reg [2:0] regulationHighCode
);

// ------------------------------------------------------------
// pin synchronisers
// ------------------------------------------------------------
reg susMeta;
reg susSync;
reg vbMeta;
reg vbSync;
reg vbLast;
reg [2:0] zoneLast;
wire vbRise = vbSync & ~vbLast;

always @(posedge clk_sys) begin
    if (!nrst) begin
        susMeta <= 1'b0;
        susSync <= 1'b0;
        vbMeta <= 1'b0;
        vbSync <= 1'b0;
        vbLast <= 1'b0;
        zoneLast <= 3'h0;
    end else begin
        susMeta <= suspend_pin;
        susSync <= susMeta;
        vbMeta <= bus_supply_input;
        vbSync <= vbMeta;
        vbLast <= vbSync;
        zoneLast <= tempZone;
    end
end

// ------------------------------------------------------------
// apb decode
// ------------------------------------------------------------
// one wait state: answer in the second access cycle after setup
wire access = psel & penable & ~pready;
wire [7:0] idx = paddr[9:2];
wire wr = access & pwrite;
wire rd = access & ~pwrite;
reg [7:0] flagsA;
reg [7:0] flagsB;
reg [7:0] enableA;
reg [7:0] enableB;
reg [7:0] suspendCtrl;
reg [7:0] limitCtrl;
reg [7:0] fastCtrl;
reg [7:0] chgenCtrl;
reg [7:0] timerCtrl;
reg [7:0] regvCtrl;
reg [7:0] prechgCtrl;
reg [7:0] next_rdata;
reg next_err;

always @* begin
    next_err = 1'b0;
    case (idx)
        `CCR_IDX_FLAGS_A: next_rdata = flagsA;
        `CCR_IDX_FLAGS_B: next_rdata = flagsB;
        `CCR_IDX_ENABLE_A: next_rdata = enableA;
        `CCR_IDX_ENABLE_B: next_rdata = enableB;
        `CCR_IDX_SUSPEND: next_rdata = suspendCtrl;
        `CCR_IDX_LIMIT: next_rdata = limitCtrl;
        `CCR_IDX_FAST: next_rdata = fastCtrl;
        `CCR_IDX_CHGEN: next_rdata = chgenCtrl;
        `CCR_IDX_TIMER: next_rdata = timerCtrl;
        `CCR_IDX_REGV: next_rdata = regvCtrl;
        `CCR_IDX_PRECHG: next_rdata = prechgCtrl;
        default: begin
            next_rdata = 8'h00;
            next_err = 1'b1;
        end
    endcase
    if (paddr[1:0] != 2'h0 || paddr[ADDR_WIDTH-1:10] != 0) begin
        next_rdata = 8'h00;
        next_err = 1'b1;
    end
end

always @(posedge clk_sys) begin
    if (!nrst) begin
        prdata <= 32'h00000000;
        pready <= 1'b0;
        pslverr <= 1'b0;
    end else begin
        pready <= access;
        pslverr <= access & next_err;
        if (rd) begin
            prdata <= {24'h000000, next_rdata};
        end
    end
end

// ------------------------------------------------------------
// event flags
// ------------------------------------------------------------
// contact timeout and hot entry flags
wire hotEntry = (tempZone == `CCR_ZONE_HOT) && (zoneLast != `CCR_ZONE_HOT);
wire [7:0] setB = eventsB | ({7'h00, contactTimeout} << `CCR_BIT_CONTACT)
    | ({7'h00, hotEntry} << `CCR_BIT_HOT);
wire rdA = rd && !next_err && idx == `CCR_IDX_FLAGS_A;
wire rdB = rd && !next_err && idx == `CCR_IDX_FLAGS_B;

always @(posedge clk_sys) begin
    if (!nrst) begin
        flagsA <= 8'h00;
        flagsB <= 8'h00;
    end else begin
        // clear returned bits, new sets win
        flagsA <= (rdA ? 8'h00 : flagsA) | eventsA;
        flagsB <= (rdB ? 8'h00 : flagsB) | setB;
    end
end

// ------------------------------------------------------------
// writable registers
// ------------------------------------------------------------
wire wrOk = wr & ~next_err;
wire [7:0] wd = pwdata[7:0];

always @(posedge clk_sys) begin
    if (!nrst) begin
        enableA <= `CCR_RST_ENABLE;
        enableB <= `CCR_RST_ENABLE;
    end else begin
        if (wrOk && idx == `CCR_IDX_ENABLE_A) begin
            enableA <= wd;
        end
        if (wrOk && idx == `CCR_IDX_ENABLE_B) begin
            enableB <= wd;
        end
    end
end

always @(posedge clk_sys) begin
    if (!nrst || vbRise) begin
        suspendCtrl <= `CCR_RST_SUSPEND;
        limitCtrl <= `CCR_RST_LIMIT;
        fastCtrl <= `CCR_RST_FAST;
        chgenCtrl <= `CCR_RST_CHGEN;
        timerCtrl <= `CCR_RST_TIMER;
        regvCtrl <= `CCR_RST_REGV;
        prechgCtrl <= `CCR_RST_PRECHG;
    end else if (wrOk) begin
        case (idx)
            `CCR_IDX_SUSPEND: suspendCtrl <= wd;
            `CCR_IDX_LIMIT: limitCtrl <= wd;
            `CCR_IDX_FAST: fastCtrl <= wd;
            `CCR_IDX_CHGEN: chgenCtrl <= wd;
            `CCR_IDX_TIMER: timerCtrl <= wd;
            `CCR_IDX_REGV: regvCtrl <= wd;
            `CCR_IDX_PRECHG: prechgCtrl <= wd;
            default: suspendCtrl <= suspendCtrl;
        endcase
    end
end

// ------------------------------------------------------------
// decoded settings
// ------------------------------------------------------------
// suspend source select
wire suspended = suspendCtrl[`CCR_BIT_SUSP_SEL] ? ~suspendCtrl[`CCR_BIT_SOFT_SUSP] : susSync;
reg [11:0] autoMa;
reg [11:0] manualMa;
reg [11:0] next_limit;
reg [6:0] next_done;
reg [5:0] next_mt;
reg [7:0] next_pt;
reg [12:0] next_regv;
reg [6:0] next_pcur;
reg [11:0] next_pthr;

always @* begin
    case (detected_source_type)
        4'h1: autoMa = `CCR_MA_500;
        4'h2: autoMa = `CCR_MA_1500;
        4'h3: autoMa = `CCR_MA_1500;
        4'h4: autoMa = `CCR_MA_500;
        4'h5: autoMa = `CCR_MA_1000;
        4'h6: autoMa = `CCR_MA_1500;
        4'h7: autoMa = `CCR_MA_500;
        default: autoMa = `CCR_MA_0;
    endcase
    case (limitCtrl[4:2])
        3'h0: manualMa = `CCR_MA_100;
        3'h1: manualMa = `CCR_MA_500;
        3'h2: manualMa = `CCR_MA_600;
        3'h3: manualMa = `CCR_MA_700;
        3'h4: manualMa = `CCR_MA_900;
        3'h5: manualMa = `CCR_MA_1000;
        3'h6: manualMa = `CCR_MA_1500;
        default: manualMa = `CCR_MA_2000;
    endcase
    case (limitCtrl[1:0])
        2'h0: next_limit = `CCR_MA_0;
        2'h1: next_limit = `CCR_MA_100;
        2'h2: next_limit = `CCR_MA_500;
        default: next_limit = manualMa;
    endcase
    if (!limitCtrl[`CCR_BIT_LIMIT_MODE]) begin
        next_limit = autoMa;
    end
    if (suspended) begin
        next_limit = `CCR_MA_0;
    end
    case (chgenCtrl[2:0])
        3'h0: next_done = 7'd10;
        3'h1: next_done = 7'd20;
        3'h2: next_done = 7'd40;
        3'h3: next_done = 7'd50;
        3'h4: next_done = 7'd60;
        3'h5: next_done = 7'd80;
        default: next_done = 7'd100;
    endcase
    case (timerCtrl[5:4])
        2'h0: next_mt = 6'd30;
        2'h1: next_mt = 6'd15;
        2'h2: next_mt = 6'd0;
        default: next_mt = 6'd60;
    endcase
    case (timerCtrl[1:0])
        2'h0: next_pt = 8'd30;
        2'h1: next_pt = 8'd60;
        2'h2: next_pt = 8'd120;
        default: next_pt = 8'd240;
    endcase
    case (regvCtrl[5:4])
        2'h0: next_regv = 13'd4050;
        2'h1: next_regv = 13'd4100;
        2'h2: next_regv = 13'd4150;
        default: next_regv = 13'd4200;
    endcase
    // high range: 50 mV steps from 4250 mV, a table keeps widths exact
    if (regvCtrl[`CCR_BIT_REG_RANGE]) begin
        case (regvCtrl[2:0])
            3'h0: next_regv = 13'd4250;
            3'h1: next_regv = 13'd4300;
            3'h2: next_regv = 13'd4350;
            3'h3: next_regv = 13'd4400;
            3'h4: next_regv = 13'd4450;
            3'h5: next_regv = 13'd4500;
            3'h6: next_regv = 13'd4550;
            default: next_regv = 13'd4600;
        endcase
    end
    case (prechgCtrl[6:5])
        2'h0: next_pcur = 7'd30;
        2'h1: next_pcur = 7'd50;
        2'h2: next_pcur = 7'd70;
        default: next_pcur = 7'd100;
    endcase
    if (prechgCtrl[`CCR_BIT_THR_SEL]) begin
        next_pthr = 12'd2700 + {8'h00, prechgCtrl[2:1], 2'h0} * 12'd25;
    end else begin
        next_pthr = 12'd2150 + {8'h00, prechgCtrl[4:3], 2'h0} * 12'd25;
    end
end

// ------------------------------------------------------------
// registered outputs
// ------------------------------------------------------------
always @(posedge clk_sys) begin
    if (!nrst) begin
        irqRequest <= 1'b0;
        forceSuspend <= 1'b0;
        inputLimitMa <= `CCR_MA_0;
        doneThresholdMa <= 7'd0;
        maintainTimerMin <= 6'd0;
        prechargeTimerMin <= 8'd0;
        regulationMv <= 13'd0;
        prechargeCurrentMa <= 7'd0;
        prechargeThresholdMv <= 12'd0;
        fastChargeCode <= 3'h0;
        regulationHighSel <= 1'b0;
        regulationHighCode <= 3'h0;
    end else begin
        irqRequest <= |(flagsA & enableA) | |(flagsB & enableB);
        forceSuspend <= suspended;
        inputLimitMa <= next_limit;
        doneThresholdMa <= next_done;
        maintainTimerMin <= next_mt;
        prechargeTimerMin <= next_pt;
        regulationMv <= next_regv;
        prechargeCurrentMa <= next_pcur;
        prechargeThresholdMv <= next_pthr;
        fastChargeCode <= fastCtrl[4:2];
        regulationHighSel <= regvCtrl[`CCR_BIT_REG_RANGE];
        regulationHighCode <= regvCtrl[2:0];
    end
end

endmodule

// ---- test/ccr_regs_checker.sv ----
// checker: apb handshake and decode ranges of the register bank
// assumes bound into ccr_charger_config_irq_regs, one clock domain
`timescale 1ns/1ps
module ccr_regs_checker (
    input wire clk_sys,
    input wire nrst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire forceSuspend,
    input wire [11:0] inputLimitMa,
    input wire [5:0] maintainTimerMin,
    input wire [6:0] prechargeCurrentMa,
    input wire [11:0] prechargeThresholdMv
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    // ----------------------------
    // bus and decode properties
    // ----------------------------
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_answer_time: assert property (psel && penable && !pready |=> pready)
        else $error("no answer after access");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_read_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000)
        else $error("read data upper bits set");
    a_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h00000000)
        else $error("refused read not zero");
    // suspend flag and limit are registered in the same cycle
    a_suspend_zero: assert property (forceSuspend |-> inputLimitMa == 12'h000)
        else $error("limit not zero in suspend");
    a_maint_codes: assert property (maintainTimerMin inside {6'h00, 6'h0F, 6'h1E, 6'h3C})
        else $error("maintain timer off table");
    a_pchg_cur: assert property (prechargeCurrentMa inside {7'h00, 7'h1E, 7'h32, 7'h46, 7'h64})
        else $error("precharge current off table");
    a_thr_codes: assert property (prechargeThresholdMv inside {12'h000, 12'h866, 12'h8CA,
        12'h92E, 12'h992, 12'hA8C, 12'hAF0, 12'hB54, 12'hBB8}) else $error("threshold off table");
endmodule

bind ccr_charger_config_irq_regs ccr_regs_checker ccr_regs_checker_i (.clk_sys, .nrst, .psel,
    .penable, .pwrite, .prdata, .pready, .pslverr, .forceSuspend, .inputLimitMa,
    .maintainTimerMin, .prechargeCurrentMa, .prechargeThresholdMv);

// ---- test/ccr_charger_config_irq_regs_tb_top.sv ----
// bench: apb master, event drivers and table model of the register bank
// assumes index*4 addressing and decodes settling within three cycles
`timescale 1ns/1ps
module ccr_charger_config_irq_regs_tb_top;
reg clk_sys = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rerr;
reg [11:0] paddr = 12'h000;
reg [31:0] pwdata = 32'h0, rdat;
reg [7:0] eventsA = 8'h00, eventsB = 8'h00, lfsr = 8'h06;
reg contactTimeout = 1'b0, suspend_pin = 1'b0, bus_supply_input = 1'b0;
reg [2:0] tempZone = 3'h0;
reg [3:0] detected_source_type = 4'h0;
reg [7:0] mdl [0:16];
wire [31:0] prdata;
wire pready, pslverr, irqRequest, forceSuspend;
wire [11:0] inputLimitMa, prechargeThresholdMv;
wire [6:0] doneThresholdMa, prechargeCurrentMa;
wire [5:0] maintainTimerMin;
wire [7:0] prechargeTimerMin;
wire [12:0] regulationMv;
wire [2:0] fastChargeCode, regulationHighCode;
wire regulationHighSel;
integer numErrors = 0, testsRun = 0, i, c;
localparam [95:0] LTAB = {12'h7D0,12'h5DC,12'h3E8,12'h384,12'h2BC,12'h258,12'h1F4,12'h064};
localparam [107:0] ATAB = {12'h000,12'h1F4,12'h5DC,12'h3E8,12'h1F4,12'h5DC,12'h5DC,12'h1F4,
    12'h000};
localparam [48:0] DTAB = {7'h64,7'h50,7'h3C,7'h32,7'h28,7'h14,7'h0A};
localparam [23:0] MTAB = {6'h3C,6'h00,6'h0F,6'h1E};
localparam [31:0] PTAB = {8'hF0,8'h78,8'h3C,8'h1E};
localparam [51:0] RTAB = {13'h1068,13'h1036,13'h1004,13'h0FD2};
localparam [27:0] CTAB = {7'h64,7'h46,7'h32,7'h1E};
localparam [95:0] TTAB = {12'hBB8,12'hB54,12'hAF0,12'hA8C,12'h992,12'h92E,12'h8CA,12'h866};

always #2.5 clk_sys = ~clk_sys;

ccr_charger_config_irq_regs ccr_charger_config_irq_regs_i (.clk_sys, .nrst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .eventsA, .eventsB, .contactTimeout,
    .tempZone, .detected_source_type, .suspend_pin, .bus_supply_input, .irqRequest,
    .forceSuspend, .inputLimitMa, .doneThresholdMa, .maintainTimerMin, .prechargeTimerMin,
    .regulationMv, .prechargeCurrentMa, .prechargeThresholdMv, .fastChargeCode,
    .regulationHighSel, .regulationHighCode);

function [7:0] dflt(input integer x);
    dflt = (x == 9) ? 8'h30 : (x == 12) ? 8'h10 : 8'h00;
endfunction
function [7:0] lfsr_next(input [7:0] s);
    lfsr_next = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
endfunction
task chk(input [31:0] seen, input [31:0] exp, input string what);
    testsRun = testsRun + 1;
    if (seen !== exp) begin
        numErrors = numErrors + 1;
        $display("BAD %0s exp %0h seen %0h", what, exp, seen);
    end
endtask
// ----------------------------
// apb master
// ----------------------------
task apb(input w, input [7:0] idx, input [7:0] d);
    integer n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    @(posedge clk_sys);
    while (pready !== 1'b1) begin
        @(posedge clk_sys);
        n = n + 1;
    end
    rdat = prdata;
    rerr = pslverr;
    // one wait state: pready seen at the edge after the access edge
    chk(n, 1, "answer");
    psel <= 1'b0;
    penable <= 1'b0;
endtask
task wr(input [7:0] idx, input [7:0] d);
    apb(1'b1, idx, d);
endtask
task rd(input [7:0] idx, input [7:0] e, input string what);
    apb(1'b0, idx, 8'h00);
    chk(rdat, {24'h0, e}, what);
endtask
// wait, then sample away from the rising edge
task tick(input integer n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
endtask
task report_and_stop;
    $display("checks %0d errors %0d", testsRun, numErrors);
    if (numErrors == 0 && testsRun > 0)
        $display("DONE - PASS");
    else
        $display("DONE - FAIL");
    $finish;
endtask

initial begin
    repeat (20000) @(posedge clk_sys);
    numErrors = numErrors + 1;
    report_and_stop;
end

initial begin
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    for (i = 6; i < 17; i = i + 1) begin
        mdl[i] = dflt(i);
        if (i != 15) rd(i, dflt(i), "dflt");
    end
    for (i = 7; i < 17; i = i + 1) begin
        lfsr = lfsr_next(lfsr);
        mdl[i] = lfsr;
        if (i != 15) wr(i, lfsr);
    end
    for (i = 7; i < 17; i = i + 1)
        if (i != 15) rd(i, mdl[i], "rw");
    apb(1'b0, 8'h0F, 8'h00);
    chk(rerr, 1, "unmapped err");
    chk(rdat, 0, "unmapped data");
    // supply edge reloads config, masks stay
    bus_supply_input <= 1'b1;
    tick(8);
    for (i = 7; i < 17; i = i + 1)
        if (i != 15) rd(i, (i < 9) ? mdl[i] : dflt(i), "reload");
    bus_supply_input <= 1'b0;
    for (c = 0; c < 32; c = c + 1) begin
        wr(10, 8'h80 | c[7:0]);
        tick(3);
        chk(inputLimitMa, c[1:0] == 2'b11 ? LTAB[c[4:2]*12 +: 12] :
            c[1:0] == 2'b10 ? 12'h1F4 : c[1:0] == 2'b01 ? 12'h064 : 12'h000, "man");
    end
    wr(9, 8'h10);
    tick(3);
    chk({forceSuspend, inputLimitMa}, 13'h1000, "soft susp");
    wr(9, 8'h00);
    tick(6);
    chk(forceSuspend, 0, "pin idle");
    @(posedge clk_sys);
    suspend_pin <= 1'b1;
    tick(6);
    chk({forceSuspend, inputLimitMa}, 13'h1000, "pin susp");
    @(posedge clk_sys);
    suspend_pin <= 1'b0;
    wr(9, 8'h30);
    wr(10, 8'h00);
    for (c = 0; c < 9; c = c + 1) begin
        @(posedge clk_sys);
        detected_source_type <= c[3:0];
        tick(4);
        chk(inputLimitMa, ATAB[c*12 +: 12], "auto");
    end
    for (c = 0; c < 8; c = c + 1) begin
        wr(12, c[7:0]);
        wr(13, {2'b00, c[1:0], 2'b00, c[1:0]});
        wr(14, {2'b00, c[1:0], 4'h0});
        wr(16, {c[2], c[1:0], c[1:0], c[1:0], 1'b0});
        tick(3);
        if (c < 7) chk(doneThresholdMa, DTAB[c*7 +: 7], "done");
        chk(maintainTimerMin, MTAB[c[1:0]*6 +: 6], "mt");
        chk(prechargeTimerMin, PTAB[c[1:0]*8 +: 8], "pt");
        chk(regulationMv, RTAB[c[1:0]*13 +: 13], "regv");
        chk(prechargeCurrentMa, CTAB[c[1:0]*7 +: 7], "pcur");
        chk(prechargeThresholdMv, TTAB[c[2:0]*12 +: 12], "pthr");
        wr(11, {3'h0, c[2:0], 2'h0});
        wr(14, {4'h0, 1'b1, c[2:0]});
        tick(3);
        chk(fastChargeCode, c, "fast");
        chk(regulationMv, 4250 + 50 * c, "regv hi");
        chk({regulationHighSel, regulationHighCode}, 8 + c, "regv sel");
    end
    wr(8, 8'h42);
    contactTimeout <= 1'b1;
    tempZone <= 3'h3;
    eventsB <= 8'h01;
    @(posedge clk_sys);
    contactTimeout <= 1'b0;
    eventsB <= 8'h00;
    tick(3);
    chk(irqRequest, 1, "irq b");
    rd(6, 8'h43, "flags b");
    tick(2);
    chk(irqRequest, 0, "irq off");
    @(posedge clk_sys);
    eventsB <= 8'h01;
    @(posedge clk_sys);
    eventsB <= 8'h00;
    tick(3);
    chk(irqRequest, 0, "mask b");
    rd(6, 8'h01, "flags b2");
    // event pulse lands on the access edge of a clearing read
    fork
        rd(6, 8'h00, "flags b3");
        begin
            repeat (2) @(posedge clk_sys);
            eventsB <= 8'h01;
            @(posedge clk_sys);
            eventsB <= 8'h00;
        end
    join
    rd(6, 8'h01, "set wins");
    wr(7, 8'h80);
    eventsA <= 8'h01;
    @(posedge clk_sys);
    eventsA <= 8'h80;
    @(posedge clk_sys);
    eventsA <= 8'h00;
    tick(3);
    chk(irqRequest, 1, "irq a");
    rd(5, 8'h81, "flags a");
    tick(2);
    chk(irqRequest, 0, "irq a off");
    report_and_stop;
end
endmodule
